// ### pcss_card_model.sv
// behavioural pc card seen from the socket pins
module pcss_card_model (
   input wire logic ref_clk,
   input wire logic card_is_io,
   input wire logic card_flag,
   input wire logic irq_want,
   input wire logic program_strobe_n,
   output logic     card_ready_busy,
   output logic     socket_protect_input
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] busy_cnt = 3'h0;
   // a write keeps the memory busy a few cycles after the strobe
   always @(posedge ref_clk) begin
      if (!program_strobe_n && !card_is_io) busy_cnt <= 3'h4;
      else if (busy_cnt != 3'h0) busy_cnt <= busy_cnt - 3'h1;
   end
   // status pins: ready or interrupt, switch level or port width
   assign card_ready_busy = card_is_io ? !irq_want : (busy_cnt == 3'h0);
   assign socket_protect_input = card_is_io ? !card_flag : card_flag;
endmodule

// ### pcss_defines.svh
// constants for the pc card socket strobe and status block
`ifndef PCSS_DEFINES_SVH
`define PCSS_DEFINES_SVH
`define PCSS_CE_IDLE      2'h3
`define PCSS_CE_EVEN      2'h2
`define PCSS_CE_ODD       2'h1
`define PCSS_CE_BOTH      2'h0
`define PCSS_STROBE_NS    300
`define PCSS_CLK_NS       100
`define PCSS_STROBE_CYC   ((`PCSS_STROBE_NS + `PCSS_CLK_NS - 1) / `PCSS_CLK_NS)
`define PCSS_STS_RDY_BIT  0
`define PCSS_STS_CARD_INTERRUPT_REQUEST_BIT 1
`define PCSS_STS_WP_BIT   2
`define PCSS_STS_IO16_BIT 3
`endif

// ### pcss_pkg.sv
// types for the pc card socket strobe and status block
package pcss_pkg;
   typedef enum logic [2:0] {
      PCSS_IDLE,
      PCSS_SETUP,
      PCSS_STROBE,
      PCSS_GAP
   } pcss_state_t;
   typedef enum logic [1:0] {
      PCSS_OP_MEM_RD,
      PCSS_OP_MEM_WR,
      PCSS_OP_IO_RD,
      PCSS_OP_IO_WR
   } pcss_op_t;
endpackage

// ### pcss_socket.sv
// socket strobe generation and card status capture for one pc card socket
// Notes on behaviour
// - chip enables go low only while the socket is enabled
// - first chip enable selects even byte, second selects odd byte
// - write strobe gates write data into card memory
// - same write strobe acts as program strobe for programmable cards
// - status input read as ready/busy for memory, interrupt for i/o cards
// - current write protect level is kept in a readable status word
// - memory writes blocked only when protect asserted and enable bit is 1
// - for i/o cards protect pin carries the sixteen bit port indication
// - no sixteen bit indication splits a 16-bit i/o access into two bytes
// - active low output enable gates read data from memory cards
`include "pcss_defines.svh"
module pcss_socket (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        socket_enable,
   input  wire logic        card_is_io,
   input  wire logic        protect_enable,
   input  wire logic        req_valid,
   input  wire logic [1:0]  req_op,
   input  wire logic [1:0]  req_bytes,
   input  wire logic        card_ready_busy,
   input  wire logic        socket_protect_input,
   output logic             req_ready,
   output logic             req_done,
   output logic             req_blocked,
   output logic             even_byte_card_select_n,
   output logic             odd_byte_card_select_n,
   output logic             program_strobe_n,
   output logic             output_enable_n,
   output logic             io_read_n,
   output logic             io_write_n,
   output logic [3:0]       interface_status,
   output logic             card_interrupt_request,
   output logic             card_port_is_sixteen_bit
);
   // ************************************************
   // status synchronisers
   // ************************************************
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync1_next;
   logic [1:0] sync2_next;

   // two stages for the two asynchronous card inputs
   always_comb begin
      sync1_next = {socket_protect_input, card_ready_busy};
      sync2_next = sync1_reg;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   logic rdy_s;
   logic wp_s;
   assign rdy_s = sync2_reg[0];
   assign wp_s  = sync2_reg[1];

   // ************************************************
   // cycle sequencer
   // ************************************************
   pcss_pkg::pcss_state_t state_reg;
   pcss_pkg::pcss_state_t state_next;
   logic [1:0] op_reg;
   logic [1:0] op_next;
   logic [1:0] lanes_reg;
   logic [1:0] lanes_next;
   logic       second_reg;
   logic       second_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [1:0] ce_reg;
   logic [1:0] ce_next;
   logic       we_reg;
   logic       we_next;
   logic       oe_reg;
   logic       oe_next;
   logic       ior_reg;
   logic       ior_next;
   logic       iow_reg;
   logic       iow_next;
   logic       rdy_reg;
   logic       rdy_next;
   logic       done_reg;
   logic       done_next;
   logic       blk_reg;
   logic       blk_next;
   logic [3:0] sts_reg;
   logic [3:0] sts_next;
   logic       irq_reg;
   logic       irq_next;
   logic       io16_reg;
   logic       io16_next;

   // chip enable code for a lane mask, bit0 even bit1 odd
   function automatic logic [1:0] pcss_ce_code(input logic [1:0] lanes);
      pcss_ce_code = ~lanes;
   endfunction

   // true when the operation is a write to card memory
   function automatic logic pcss_is_mem_wr(input logic [1:0] op);
      pcss_is_mem_wr = (op == 2'(pcss_pkg::PCSS_OP_MEM_WR));
   endfunction

   // sequencer next state and strobes
   always_comb begin
      state_next  = state_reg;
      op_next     = op_reg;
      lanes_next  = lanes_reg;
      second_next = second_reg;
      cnt_next    = cnt_reg;
      ce_next     = `PCSS_CE_IDLE;
      we_next     = 1'b1;
      oe_next     = 1'b1;
      ior_next    = 1'b1;
      iow_next    = 1'b1;
      rdy_next    = 1'b0;
      done_next   = 1'b0;
      blk_next    = 1'b0;
      unique case (state_reg)
         pcss_pkg::PCSS_IDLE: begin
            rdy_next = socket_enable;
            if (req_valid && rdy_reg && socket_enable) begin
               op_next     = req_op;
               lanes_next  = req_bytes;
               second_next = 1'b0;
               rdy_next    = 1'b0;
               if (pcss_is_mem_wr(req_op) && wp_s && protect_enable) begin
                  done_next = 1'b1;
                  blk_next  = 1'b1;
               end else begin
                  state_next = pcss_pkg::PCSS_SETUP;
               end
            end
         end
         pcss_pkg::PCSS_SETUP: begin
            // split when card lacks sixteen bit port support
            // protect pin high on an i/o card means no sixteen bit port
            if (op_reg[1] && lanes_reg == 2'h3 && wp_s) begin
               lanes_next  = 2'h1;
               second_next = 1'b1;
            end
            ce_next    = socket_enable ? pcss_ce_code(lanes_next) : `PCSS_CE_IDLE;
            cnt_next   = 4'(`PCSS_STROBE_CYC);
            state_next = pcss_pkg::PCSS_STROBE;
         end
         pcss_pkg::PCSS_STROBE: begin
            ce_next  = socket_enable ? pcss_ce_code(lanes_reg) : `PCSS_CE_IDLE;
            we_next  = !pcss_is_mem_wr(op_reg);
            oe_next  = !(op_reg == 2'(pcss_pkg::PCSS_OP_MEM_RD));
            ior_next = !(op_reg == 2'(pcss_pkg::PCSS_OP_IO_RD));
            iow_next = !(op_reg == 2'(pcss_pkg::PCSS_OP_IO_WR));
            cnt_next = cnt_reg - 4'h1;
            // strobes stay low through the last count; the gap raises them
            if (cnt_reg == 4'h1) begin
               state_next = pcss_pkg::PCSS_GAP;
            end
         end
         pcss_pkg::PCSS_GAP: begin
            if (second_reg) begin
               second_next = 1'b0;
               lanes_next  = 2'h2; // odd byte cycle follows
               ce_next     = socket_enable ? `PCSS_CE_ODD : `PCSS_CE_IDLE;
               cnt_next    = 4'(`PCSS_STROBE_CYC);
               state_next  = pcss_pkg::PCSS_STROBE;
            end else begin
               done_next  = 1'b1;
               state_next = pcss_pkg::PCSS_IDLE;
            end
         end
         default: state_next = pcss_pkg::PCSS_IDLE;
      endcase
   end

   // status word and the shared pins read by card type
   always_comb begin
      sts_next = 4'h0;
      sts_next[`PCSS_STS_RDY_BIT]  = !card_is_io && rdy_s;
      sts_next[`PCSS_STS_CARD_INTERRUPT_REQUEST_BIT] = card_is_io && !rdy_s;
      sts_next[`PCSS_STS_WP_BIT]   = !card_is_io && wp_s;
      sts_next[`PCSS_STS_IO16_BIT] = card_is_io && !wp_s;
      irq_next  = card_is_io && !rdy_s;
      io16_next = card_is_io && !wp_s;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= pcss_pkg::PCSS_IDLE;
         op_reg     <= 2'h0;
         lanes_reg  <= 2'h0;
         second_reg <= 1'b0;
         cnt_reg    <= 4'h0;
         ce_reg     <= `PCSS_CE_IDLE;
         we_reg     <= 1'b1;
         oe_reg     <= 1'b1;
         ior_reg    <= 1'b1;
         iow_reg    <= 1'b1;
         rdy_reg    <= 1'b0;
         done_reg   <= 1'b0;
         blk_reg    <= 1'b0;
         sts_reg    <= 4'h0;
         irq_reg    <= 1'b0;
         io16_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         op_reg     <= op_next;
         lanes_reg  <= lanes_next;
         second_reg <= second_next;
         cnt_reg    <= cnt_next;
         ce_reg     <= ce_next;
         we_reg     <= we_next;
         oe_reg     <= oe_next;
         ior_reg    <= ior_next;
         iow_reg    <= iow_next;
         rdy_reg    <= rdy_next;
         done_reg   <= done_next;
         blk_reg    <= blk_next;
         sts_reg    <= sts_next;
         irq_reg    <= irq_next;
         io16_reg   <= io16_next;
      end
   end

   // outputs straight from flip-flops
   assign req_ready                = rdy_reg;
   assign req_done                 = done_reg;
   assign req_blocked              = blk_reg;
   assign even_byte_card_select_n  = ce_reg[0];
   assign odd_byte_card_select_n   = ce_reg[1];
   assign program_strobe_n         = we_reg;
   assign output_enable_n          = oe_reg;
   assign io_read_n                = ior_reg;
   assign io_write_n               = iow_reg;
   assign interface_status         = sts_reg;
   assign card_interrupt_request   = irq_reg;
   assign card_port_is_sixteen_bit = io16_reg;
endmodule

// ### pcss_socket_assertions.sv
// assertions on the socket strobe and status ports
module pcss_socket_assertions (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       socket_enable,
   input wire logic       card_is_io,
   input wire logic       card_ready_busy,
   input wire logic       socket_protect_input,
   input wire logic       req_done,
   input wire logic       req_blocked,
   input wire logic       even_byte_card_select_n,
   input wire logic       odd_byte_card_select_n,
   input wire logic       program_strobe_n,
   input wire logic       output_enable_n,
   input wire logic [3:0] interface_status,
   input wire logic       card_interrupt_request,
   input wire logic       card_port_is_sixteen_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // both lanes idle
   wire logic idle_n = even_byte_card_select_n & odd_byte_card_select_n;
   sel_idle_a: assert property (!socket_enable [*2] |-> idle_n)
      else $error("select low while socket disabled");
   wr_sel_a: assert property (!program_strobe_n |-> !idle_n)
      else $error("write strobe without select");
   pgm_width_a: assert property (
      $fell(program_strobe_n) |-> !program_strobe_n [*3] ##1 program_strobe_n)
      else $error("write strobe width wrong");
   wr_blocked_a: assert property (
      req_blocked |-> req_done && $past(program_strobe_n) && $past(program_strobe_n, 2))
      else $error("blocked write pulsed strobe");
   rd_gate_a: assert property (!output_enable_n |-> !idle_n && program_strobe_n)
      else $error("read strobe without select");
   wp_status_a: assert property (
      (!card_is_io && $stable(socket_protect_input)) [*5] |->
      interface_status[2] == socket_protect_input) else $error("protect status stale");
   irq_follow_a: assert property (
      (card_is_io && $stable(card_ready_busy)) [*5] |->
      card_interrupt_request == !card_ready_busy) else $error("interrupt stale");
   port_wide_a: assert property (
      (card_is_io && $stable(socket_protect_input)) [*5] |->
      card_port_is_sixteen_bit == !socket_protect_input) else $error("port width stale");
endmodule

// ### pcss_socket_tb.sv
// self-checking bench for the pc card socket strobe and status block
module pcss_socket_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {pcss_pkg::pcss_op_t op; logic [1:0] by; logic io, fl, pe, bl; int c[5];} pcss_row_t;
   logic       ref_clk = 1'b0, rst_n = 1'b0, socket_enable = 1'b1, card_is_io = 1'b0;
   logic       protect_enable = 1'b0, req_valid = 1'b0, card_flag = 1'b0, irq_want = 1'b0;
   logic [1:0] req_op = 2'h0, req_bytes = 2'h0;
   logic [3:0] interface_status;
   logic       req_ready, req_done, req_blocked, even_byte_card_select_n, odd_byte_card_select_n;
   logic       program_strobe_n, output_enable_n, io_read_n, io_write_n, card_interrupt_request;
   logic       card_port_is_sixteen_bit, card_ready_busy, socket_protect_input;
   int         miscompares = 0, tests_run = 0;
   // counts: write strobe, read strobe, io strobe, even select, odd select
   pcss_row_t  rows[7] = '{
      '{pcss_pkg::PCSS_OP_MEM_WR, 2'h3, 0, 0, 1, 0, '{3, 0, 0, 4, 4}},
      '{pcss_pkg::PCSS_OP_MEM_WR, 2'h3, 0, 1, 1, 1, '{0, 0, 0, 0, 0}},
      '{pcss_pkg::PCSS_OP_MEM_WR, 2'h1, 0, 1, 0, 0, '{3, 0, 0, 4, 0}},
      '{pcss_pkg::PCSS_OP_MEM_RD, 2'h2, 0, 1, 1, 0, '{0, 3, 0, 0, 4}},
      '{pcss_pkg::PCSS_OP_IO_RD, 2'h3, 1, 1, 0, 0, '{0, 0, 3, 4, 4}},
      '{pcss_pkg::PCSS_OP_IO_WR, 2'h3, 1, 0, 0, 0, '{0, 0, 6, 4, 4}},
      '{pcss_pkg::PCSS_OP_IO_RD, 2'h1, 1, 0, 0, 0, '{0, 0, 3, 4, 0}}};
   always #50 ref_clk = ~ref_clk;
   pcss_socket i_dut (.ref_clk, .rst_n, .socket_enable, .card_is_io, .protect_enable,
      .req_valid, .req_op, .req_bytes, .card_ready_busy, .socket_protect_input, .req_ready,
      .req_done, .req_blocked, .even_byte_card_select_n, .odd_byte_card_select_n,
      .program_strobe_n, .output_enable_n, .io_read_n, .io_write_n, .interface_status,
      .card_interrupt_request, .card_port_is_sixteen_bit);
   pcss_card_model i_card (.ref_clk, .card_is_io, .card_flag, .irq_want, .program_strobe_n,
      .card_ready_busy, .socket_protect_input);
   task automatic chk_bit(string nm, logic e, logic g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_cnt(string nm, int e, int g);
      tests_run++;
      if (g != e) begin
         miscompares++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // set up the card, issue one request and count strobe cycles up to done
   task automatic run_row(pcss_row_t r);
      int c[5] = '{0, 0, 0, 0, 0};
      int n;
      @(posedge ref_clk);
      card_is_io <= r.io;
      card_flag <= r.fl;
      protect_enable <= r.pe;
      repeat (6) @(posedge ref_clk);
      for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge ref_clk);
      if (n == 20) begin
         miscompares++;
         summarize();
      end
      @(posedge ref_clk);
      req_op <= r.op;
      req_bytes <= r.by;
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      for (n = 0; n < 15 && req_done !== 1'b1; n++) begin
         @(negedge ref_clk);
         c[0] += program_strobe_n === 1'b0;
         c[1] += output_enable_n === 1'b0;
         c[2] += (io_read_n & io_write_n) === 1'b0;
         c[3] += even_byte_card_select_n === 1'b0;
         c[4] += odd_byte_card_select_n === 1'b0;
      end
      if (n == 15) begin
         miscompares++;
         summarize();
      end
      chk_bit("blocked", r.bl, req_blocked);
      chk_cnt("write strobe", r.c[0], c[0]);
      chk_cnt("read strobe", r.c[1], c[1]);
      chk_cnt("io strobe", r.c[2], c[2]);
      chk_cnt("even select", r.c[3], c[3]);
      chk_cnt("odd select", r.c[4], c[4]);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      chk_bit("reset idle", 1'b1, even_byte_card_select_n & program_strobe_n);
      chk_bit("reset status", 1'b1, interface_status === 4'h0);
      rst_n <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      run_row(rows[0]);
      @(negedge ref_clk);
      chk_bit("busy status", 1'b0, interface_status[0]);
      repeat (10) @(negedge ref_clk);
      chk_bit("ready status", 1'b1, interface_status[0]);
      run_row(rows[1]);
      chk_bit("protect status", 1'b1, interface_status[2]);
      @(posedge ref_clk);
      card_is_io <= 1'b1;
      irq_want <= 1'b1;
      card_flag <= 1'b1;
      repeat (6) @(negedge ref_clk);
      chk_bit("interrupt", 1'b1, card_interrupt_request & interface_status[1]);
      chk_bit("wide port", 1'b1, card_port_is_sixteen_bit);
      chk_bit("wide status", 1'b1, interface_status[3]);
      // start a wide i/o read, then pull the socket enable during its strobe
      @(posedge ref_clk);
      req_op <= pcss_pkg::PCSS_OP_IO_RD;
      req_bytes <= 2'h3;
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      socket_enable <= 1'b0;
      req_valid <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk_bit("cut select", 1'b1, even_byte_card_select_n & odd_byte_card_select_n);
      repeat (8) @(negedge ref_clk);
      chk_bit("disabled idle", 1'b1, even_byte_card_select_n & odd_byte_card_select_n);
      chk_bit("disabled ready", 1'b0, req_ready);
      summarize();
   end
endmodule
bind pcss_socket pcss_socket_assertions i_chk (.ref_clk, .rst_n, .socket_enable, .card_is_io,
   .card_ready_busy, .socket_protect_input, .req_done, .req_blocked, .even_byte_card_select_n,
   .odd_byte_card_select_n, .program_strobe_n, .output_enable_n, .interface_status,
   .card_interrupt_request, .card_port_is_sixteen_bit);
